// >>> rtl/dma_arb_cfg.svh
// Offsets, field positions, codes and reset values of the request arbiter
`ifndef DMA_ARB_CFG_SVH
`define DMA_ARB_CFG_SVH
// Register byte offsets
`define CHAN_BASE 8'h00
`define CHAN_STRIDE 8'h04
`define OPCTL_OFS 8'h10
`define STATUS_OFS 8'h14
// Channel control fields
`define CC_EN 0
`define CC_TE 1
`define CC_DS 2
`define CC_BURST 3
`define CC_U16 4
`define CC_IND 5
`define CC_RS_LO 8
`define CC_RS_HI 11
// Operation control fields
`define OC_ME 0
`define OC_NMI 1
`define OC_AE 2
`define OC_PR_LO 8
`define OC_PR_HI 9
// Status fields
`define ST_REQ_LO 0
`define ST_REQ_HI 3
`define ST_ERR_LO 4
`define ST_ERR_HI 7
`define ST_CH_LO 8
`define ST_CH_HI 9
`define ST_BUSY 12
`define ST_TOP_LO 16
`define ST_TOP_HI 17
// Request source codes
`define RS_DUAL 4'h0
`define RS_SGL_TO_DEV 4'h2
`define RS_SGL_FROM_DEV 4'h3
`define RS_AUTO 4'h4
`define RS_PER_BASE 4'hA
`define PER_TIMER 3'h5
// Priority modes and fixed orders (rank 0 in the low pair)
`define PR_FIX_A 2'h0
`define PR_FIX_B 2'h1
`define PR_FIX_C 2'h2
`define PR_RR 2'h3
`define ORDER_A 8'hE4
`define ORDER_B 8'h78
`define ORDER_C 8'hD2
// Reset values
`define RST_BIT 1'h0
`define RST_PAIR 2'h0
`define RST_NIB 4'h0
`define RST_WORD 32'h0
`define RST_EXT 2'h3
`endif

// >>> rtl/dma_arb_pkg.sv
// Types shared by the request arbiter
package dma_arb_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_BUSY} xfer_state_e;
    typedef logic [1:0] chan_t;
    typedef logic [3:0] rs_code_t;
    typedef logic [2:0] per_idx_t;
endpackage

// >>> rtl/dma_request_select_arbiter.sv
// Request source selection, qualification and channel arbitration for four DMA channels
// Notes on behaviour
// - Per-channel 4-bit select picks request mode
// - Auto request runs when fully enabled
// - External request needs all enables, no flags
// - Channels 0,1: level or falling edge
// - Codes 0000, 0010, 0011 decode address mode
// - No peripheral request with 16-byte unit
// - Codes 1010 to 1111 map peripheral sources
// - Serial, converter: cycle-steal only; timer both
// - Selected peripheral request hidden from CPU
// - Peripheral request cleared when served
// - Simultaneous requests: grant by priority
// - Two-bit priority select decodes four modes
// - Round-robin: served channel drops to lowest
// - Rotation keeps cyclic order
// - Round-robin starts 0 highest after reset
// - Waiting requests rearbitrated after each transfer
// - Dual address: direct or indirect variant
// - Single address only acknowledged device with memory
// - Requester need not be source or destination
`timescale 1ns/10ps
`include "dma_arb_cfg.svh"

module dma_request_select_arbiter (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Request sources
    input wire logic [1:0] EXT_REQUEST_N,
    input wire logic [5:0] PERIPH_REQ,
    // Events from the transfer engine
    input wire logic UNIT_DONE,
    input wire logic LAST_UNIT,
    input wire logic [3:0] XFER_END,
    input wire logic NMI_EVENT,
    input wire logic ADDR_ERROR,
    // Grant to the transfer engine
    output logic GRANT_VALID,
    output logic [1:0] GRANT_CH,
    output logic GRANT_BURST,
    output logic GRANT_SINGLE,
    output logic GRANT_TO_DEVICE,
    output logic GRANT_INDIRECT,
    // Peripheral and device handshakes
    output logic [1:0] EXT_ACKNOWLEDGE,
    output logic [5:0] PERIPH_CLEAR,
    output logic [5:0] CPU_IRQ
);

    // Channel control state
    logic [3:0] en, te, te_seen, ds, burst, u16, ind;
    dma_arb_pkg::rs_code_t rs [4];
    // Operation control state
    logic me, nmi, ae, nmi_seen, ae_seen;
    logic [1:0] prio;
    dma_arb_pkg::chan_t rr_top;
    // Arbiter state
    dma_arb_pkg::xfer_state_e state;
    dma_arb_pkg::chan_t gch;
    logic [1:0] ext_prev, ext_pend;

    // Per-channel decode results
    logic [3:0] chan_en, is_auto, is_ext, is_per, per_ok, cfg_err, req, stop_ext, ch_wr, ch_rd;
    dma_arb_pkg::per_idx_t pidx [4];
    logic [31:0] chan_word [4];
    logic [7:0] periph_vec;
    logic [5:0] per_used;

    // Global decode
    logic op_wr, op_rd, st_rd, blocked, start, found, cont, stop, drop;
    logic [7:0] order;
    logic [2:0] pick_res;
    dma_arb_pkg::chan_t win_ch;
    logic [31:0] op_word, st_word, rd_mux;
    logic [1:0] fell;

    assign periph_vec = {2'b00, PERIPH_REQ};
    assign op_wr = REG_WR && (REG_ADDR == `OPCTL_OFS);
    assign op_rd = REG_RD && (REG_ADDR == `OPCTL_OFS);
    assign st_rd = REG_RD && (REG_ADDR == `STATUS_OFS);
    assign blocked = !me || nmi || ae;
    assign fell = ext_prev & ~EXT_REQUEST_N;

    // Request decode, qualification and configuration checks per channel
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            localparam logic [7:0] OFS = 8'(`CHAN_BASE + c * `CHAN_STRIDE);
            logic ext_code, ext_hit;
            assign ch_wr[c] = REG_WR && (REG_ADDR == OFS);
            assign ch_rd[c] = REG_RD && (REG_ADDR == OFS);
            // Full enable: channel and master on, no end, NMI or address error
            assign chan_en[c] = en[c] && !te[c] && !blocked;
            assign is_auto[c] = (rs[c] == `RS_AUTO);
            assign ext_code = (rs[c] == `RS_DUAL) || (rs[c] == `RS_SGL_TO_DEV) || (rs[c] == `RS_SGL_FROM_DEV);
            // Only channels 0 and 1 have a request pin
            assign is_ext[c] = ext_code && (c < 2);
            assign is_per[c] = (rs[c] >= `RS_PER_BASE);
            assign pidx[c] = 3'(rs[c] - `RS_PER_BASE);
            // Serial and converter sources refuse burst; no peripheral with 16-byte unit
            assign per_ok[c] = is_per[c] && !u16[c] && (!burst[c] || pidx[c] == `PER_TIMER);
            assign cfg_err[c] = (ext_code && c >= 2) || (is_per[c] && !per_ok[c]);
            assign ext_hit = ds[c] ? ext_pend[c % 2] : !EXT_REQUEST_N[c % 2];
            // Level pin dropped during burst hands the bus back
            assign stop_ext[c] = is_ext[c] && !ds[c] && EXT_REQUEST_N[c % 2];
            // Requester may be source, destination or neither; undefined codes never request
            assign req[c] = chan_en[c] && (is_auto[c] || (is_ext[c] && ext_hit)
                || (per_ok[c] && periph_vec[pidx[c]]));
            // Readback word
            always_comb begin
                chan_word[c] = `RST_WORD;
                chan_word[c][`CC_EN] = en[c];
                chan_word[c][`CC_TE] = te[c];
                chan_word[c][`CC_DS] = ds[c];
                chan_word[c][`CC_BURST] = burst[c];
                chan_word[c][`CC_U16] = u16[c];
                chan_word[c][`CC_IND] = ind[c];
                chan_word[c][`CC_RS_HI:`CC_RS_LO] = rs[c];
            end
            // Control bits and mode select
            always_ff @(posedge REF_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    en[c] <= `RST_BIT;
                    ds[c] <= `RST_BIT;
                    burst[c] <= `RST_BIT;
                    u16[c] <= `RST_BIT;
                    ind[c] <= `RST_BIT;
                    rs[c] <= `RST_NIB;
                end else if (ch_wr[c]) begin
                    en[c] <= REG_WDATA[`CC_EN];
                    ds[c] <= REG_WDATA[`CC_DS];
                    burst[c] <= REG_WDATA[`CC_BURST];
                    u16[c] <= REG_WDATA[`CC_U16];
                    ind[c] <= REG_WDATA[`CC_IND];
                    rs[c] <= REG_WDATA[`CC_RS_HI:`CC_RS_LO];
                end
            end
            // End flag: set by engine, cleared by writing 0 after reading 1; set wins
            always_ff @(posedge REF_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    te[c] <= `RST_BIT;
                    te_seen[c] <= `RST_BIT;
                end else if (XFER_END[c]) begin
                    te[c] <= 1'b1;
                end else if (ch_wr[c] && te_seen[c] && !REG_WDATA[`CC_TE]) begin
                    te[c] <= 1'b0;
                    te_seen[c] <= 1'b0;
                end else if (ch_rd[c] && te[c]) begin
                    te_seen[c] <= 1'b1;
                end
            end
        end
    endgenerate

    // Peripheral sources claimed by any channel are kept away from the CPU
    generate
        for (c = 0; c < 6; c++) begin : g_per
            assign per_used[c] = (rs[0] == 4'(`RS_PER_BASE + c)) || (rs[1] == 4'(`RS_PER_BASE + c))
                || (rs[2] == 4'(`RS_PER_BASE + c)) || (rs[3] == 4'(`RS_PER_BASE + c));
        end
    endgenerate

    // Priority order from the mode bits; round-robin order counts up from the top channel
    assign order = (prio == `PR_FIX_A) ? `ORDER_A :
                   (prio == `PR_FIX_B) ? `ORDER_B :
                   (prio == `PR_FIX_C) ? `ORDER_C :
                   {2'(rr_top + 2'd3), 2'(rr_top + 2'd2), 2'(rr_top + 2'd1), rr_top};

    // Highest-ranked requesting channel; rank 0 is scanned last so it wins
    function automatic logic [2:0] pick(input logic [3:0] r, input logic [7:0] ord);
        logic [2:0] res;
        res = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (r[ord[2 * i +: 2]]) begin
                res = {1'b1, ord[2 * i +: 2]};
            end
        end
        return res;
    endfunction

    assign pick_res = pick(req, order);
    assign found = pick_res[2];
    assign win_ch = pick_res[1:0];
    // New arbitration only from idle, so a request arriving mid-transfer waits
    assign start = (state == dma_arb_pkg::ST_IDLE) && found;
    // Burst keeps the bus unless this was the last unit or the request went away
    assign cont = burst[gch] && !LAST_UNIT && req[gch] && !stop_ext[gch];
    // Channel or master enable dropped, or a flag raised, ends the transfer at once
    assign stop = !chan_en[gch];
    // One end condition shared by the grant and the acknowledge, so both fall at the same edge
    assign drop = stop || (UNIT_DONE && !cont);

    // Operation and status readback
    always_comb begin
        op_word = `RST_WORD;
        op_word[`OC_ME] = me;
        op_word[`OC_NMI] = nmi;
        op_word[`OC_AE] = ae;
        op_word[`OC_PR_HI:`OC_PR_LO] = prio;
        st_word = `RST_WORD;
        st_word[`ST_REQ_HI:`ST_REQ_LO] = req;
        st_word[`ST_ERR_HI:`ST_ERR_LO] = cfg_err;
        st_word[`ST_CH_HI:`ST_CH_LO] = gch;
        st_word[`ST_BUSY] = (state == dma_arb_pkg::ST_BUSY);
        st_word[`ST_TOP_HI:`ST_TOP_LO] = rr_top;
    end

    // Unmapped addresses read as zero
    assign rd_mux = |ch_rd ? chan_word[REG_ADDR[3:2]] : op_rd ? op_word : st_rd ? st_word : `RST_WORD;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= `RST_WORD;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : `RST_WORD;
        end
    end

    // Master enable and priority mode
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            me <= `RST_BIT;
            prio <= `RST_PAIR;
        end else if (op_wr) begin
            me <= REG_WDATA[`OC_ME];
            prio <= REG_WDATA[`OC_PR_HI:`OC_PR_LO];
        end
    end

    // NMI and address error flags: a new event beats a clearing write
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            nmi <= `RST_BIT;
            nmi_seen <= `RST_BIT;
        end else if (NMI_EVENT) begin
            nmi <= 1'b1;
        end else if (op_wr && nmi_seen && !REG_WDATA[`OC_NMI]) begin
            nmi <= 1'b0;
            nmi_seen <= 1'b0;
        end else if (op_rd && nmi) begin
            nmi_seen <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ae <= `RST_BIT;
            ae_seen <= `RST_BIT;
        end else if (ADDR_ERROR) begin
            ae <= 1'b1;
        end else if (op_wr && ae_seen && !REG_WDATA[`OC_AE]) begin
            ae <= 1'b0;
            ae_seen <= 1'b0;
        end else if (op_rd && ae) begin
            ae_seen <= 1'b1;
        end
    end

    // Falling-edge capture; the latch holds until that channel is granted
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ext_prev <= `RST_EXT;
            ext_pend <= `RST_PAIR;
        end else begin
            ext_prev <= EXT_REQUEST_N;
            ext_pend[0] <= fell[0] || (ext_pend[0] && !(start && win_ch == 2'd0));
            ext_pend[1] <= fell[1] || (ext_pend[1] && !(start && win_ch == 2'd1));
        end
    end

    // Round-robin pointer: the channel after the served one goes to the top
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rr_top <= `RST_PAIR;
        end else if (state == dma_arb_pkg::ST_BUSY && UNIT_DONE && prio == `PR_RR) begin
            rr_top <= 2'(gch + 2'd1);
        end
    end

    // Grant state; the attributes are held steady for the whole transfer
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= dma_arb_pkg::ST_IDLE;
            gch <= `RST_PAIR;
            GRANT_CH <= `RST_PAIR;
            GRANT_VALID <= `RST_BIT;
            GRANT_BURST <= `RST_BIT;
            GRANT_SINGLE <= `RST_BIT;
            GRANT_TO_DEVICE <= `RST_BIT;
            GRANT_INDIRECT <= `RST_BIT;
        end else begin
            unique case (state)
                dma_arb_pkg::ST_IDLE: begin
                    if (found) begin
                        state <= dma_arb_pkg::ST_BUSY;
                        gch <= win_ch;
                        GRANT_CH <= win_ch;
                        GRANT_VALID <= 1'b1;
                        GRANT_BURST <= burst[win_ch];
                        GRANT_SINGLE <= is_ext[win_ch] && rs[win_ch] != `RS_DUAL;
                        GRANT_TO_DEVICE <= rs[win_ch] == `RS_SGL_TO_DEV;
                        GRANT_INDIRECT <= ind[win_ch] && !(is_ext[win_ch] && rs[win_ch] != `RS_DUAL);
                    end
                end
                dma_arb_pkg::ST_BUSY: begin
                    if (drop) begin
                        state <= dma_arb_pkg::ST_IDLE;
                        GRANT_VALID <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Acknowledge, peripheral withdraw and CPU interrupt pass-through
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EXT_ACKNOWLEDGE <= `RST_PAIR;
            PERIPH_CLEAR <= 6'h00;
            CPU_IRQ <= 6'h00;
        end else begin
            EXT_ACKNOWLEDGE[0] <= start ? (win_ch == 2'd0 && is_ext[0]) : (EXT_ACKNOWLEDGE[0] && !drop);
            EXT_ACKNOWLEDGE[1] <= start ? (win_ch == 2'd1 && is_ext[1]) : (EXT_ACKNOWLEDGE[1] && !drop);
            // Cycle-steal withdraws with the grant, burst at the end of the last unit
            for (int k = 0; k < 6; k++) begin
                PERIPH_CLEAR[k] <= (start && per_ok[win_ch] && !burst[win_ch] && pidx[win_ch] == 3'(k))
                    || (state == dma_arb_pkg::ST_BUSY && UNIT_DONE && LAST_UNIT && per_ok[gch]
                    && burst[gch] && pidx[gch] == 3'(k));
            end
            CPU_IRQ <= PERIPH_REQ & ~per_used;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    property p_grant_winner;
        start |=> GRANT_VALID && GRANT_CH == $past(win_ch);
    endproperty
    a_grant_winner: assert property (p_grant_winner) else $error("grant does not match winner");

    property p_fixed_top;
        (start && prio == `PR_FIX_C && req[2]) |=> GRANT_CH == 2'd2;
    endproperty
    a_fixed_top: assert property (p_fixed_top) else $error("channel 2 lost in mode 10");

    property p_rr_rotate;
        (state == dma_arb_pkg::ST_BUSY && UNIT_DONE && prio == `PR_RR) |=> rr_top == 2'($past(gch) + 2'd1);
    endproperty
    a_rr_rotate: assert property (p_rr_rotate) else $error("round-robin did not rotate");

    property p_undefined_code;
        !(is_auto[0] || is_ext[0] || per_ok[0]) |-> !req[0];
    endproperty
    a_undefined_code: assert property (p_undefined_code) else $error("undefined code requested");

    property p_edge_latch;
        (ds[1] && $past(EXT_REQUEST_N[1]) && !EXT_REQUEST_N[1]) |=> ext_pend[1];
    endproperty
    a_edge_latch: assert property (p_edge_latch) else $error("falling edge not latched");

    property p_irq_hidden;
        (per_used[3] && PERIPH_REQ[3]) |=> !CPU_IRQ[3];
    endproperty
    a_irq_hidden: assert property (p_irq_hidden) else $error("claimed request reached CPU");

    property p_cs_withdraw;
        (start && per_ok[win_ch] && !burst[win_ch]) |=> PERIPH_CLEAR[$past(pidx[win_ch])] && GRANT_VALID;
    endproperty
    a_cs_withdraw: assert property (p_cs_withdraw) else $error("cycle-steal request not withdrawn");

    property p_abort;
        (state == dma_arb_pkg::ST_BUSY && !chan_en[gch]) |=> !GRANT_VALID ##1 !GRANT_VALID || $past(found);
    endproperty
    a_abort: assert property (p_abort) else $error("grant kept after disable");

    property p_single_pins;
        GRANT_SINGLE |-> GRANT_CH < 2'd2 && !GRANT_INDIRECT;
    endproperty
    a_single_pins: assert property (p_single_pins) else $error("single address on wrong channel");

    property p_bad_config;
        cfg_err[0] |-> !req[0] && !is_auto[0];
    endproperty
    a_bad_config: assert property (p_bad_config) else $error("illegal combination requested");

endmodule

// >>> test/dma_req_sources.sv
// Model of the external requesters and on-chip peripheral request sources
`timescale 1ns/10ps
module dma_req_sources (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Commands from the bench
    input wire logic [1:0] ext_want,
    input wire logic [5:0] per_set,
    // Handshake from the arbiter
    input wire logic [5:0] per_clear,
    // Request lines
    output logic [1:0] ext_request_n,
    output logic [5:0] periph_req
);
    // Pins idle high on their pull-up; a requester holds low until told to let go
    assign ext_request_n = ~ext_want;
    // Set pulses stand for a peripheral whose interrupt enable is already on
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_req <= 6'h00;
        end else begin
            periph_req <= (periph_req & ~per_clear) | per_set;
        end
    end
endmodule

// >>> test/dma_request_select_arbiter_tb.sv
// Self-checking bench for the request select arbiter
`timescale 1ns/10ps
module dma_request_select_arbiter_tb;
    logic ref_clk, arst_n, reg_wr, reg_rd, unit_done, last_unit, nmi_event, addr_error;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0] ext_request_n, ext_want, ext_ack, grant_ch, rr_top;
    logic [5:0] periph_req, per_set, periph_clear, cpu_irq;
    logic [3:0] xfer_end, xc;
    logic grant_valid, grant_burst, grant_single, grant_to_dev, grant_ind;
    int failures, cmp_count;

    dma_request_select_arbiter DUT (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .EXT_REQUEST_N(ext_request_n),
        .PERIPH_REQ(periph_req), .UNIT_DONE(unit_done), .LAST_UNIT(last_unit), .XFER_END(xfer_end),
        .NMI_EVENT(nmi_event), .ADDR_ERROR(addr_error), .GRANT_VALID(grant_valid), .GRANT_CH(grant_ch),
        .GRANT_BURST(grant_burst), .GRANT_SINGLE(grant_single), .GRANT_TO_DEVICE(grant_to_dev),
        .GRANT_INDIRECT(grant_ind), .EXT_ACKNOWLEDGE(ext_ack), .PERIPH_CLEAR(periph_clear), .CPU_IRQ(cpu_irq)
    );
    dma_req_sources partner (
        .clk(ref_clk), .arst_n(arst_n), .ext_want(ext_want), .per_set(per_set),
        .per_clear(periph_clear), .ext_request_n(ext_request_n), .periph_req(periph_req)
    );

    // Free-running 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Runaway guard, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        complete_run();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Always let an edge pass: an ending grant still shows in the time step of its last edge
    task automatic gnt(input logic [1:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (grant_valid !== 1'b1 && n < 30);
        chk(grant_valid, 1'b1);
        chk(grant_ch, exp);
    endtask

    task automatic none();
        repeat (8) begin
            @(posedge ref_clk);
            #1 chk(grant_valid, 1'b0);
        end
    endtask

    task automatic unit(input logic last);
        @(posedge ref_clk);
        unit_done <= 1'b1;
        last_unit <= last;
        @(posedge ref_clk);
        unit_done <= 1'b0;
        last_unit <= 1'b0;
    endtask

    task automatic raise(input logic [5:0] m);
        @(posedge ref_clk);
        per_set <= m;
        @(posedge ref_clk);
        per_set <= 6'h00;
    endtask

    // Master enable off first, so nothing is left granted between scenarios
    task automatic idle();
        wr(8'h10, 32'h0);
        for (int c = 0; c < 4; c++) wr(8'(4 * c), 32'h0);
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic setup(input int ch, input logic [31:0] v);
        idle();
        wr(8'(4 * ch), v);
        wr(8'h10, 32'h1);
    endtask

    // Expected winner: order table per mode, highest first
    function automatic logic [1:0] pick(input logic [1:0] m, input logic [3:0] msk, input logic [1:0] top);
        logic [7:0] o;
        o = (m == 2'h0) ? 8'h1B : (m == 2'h1) ? 8'h2D : (m == 2'h2) ? 8'h87 :
            {top, 2'(top + 2'h1), 2'(top + 2'h2), 2'(top + 2'h3)};
        for (int i = 0; i < 4; i++) if (msk[o[7 - 2 * i -: 2]]) return o[7 - 2 * i -: 2];
        return 2'h0;
    endfunction

    // All selected auto channels become ready at the same edge
    task automatic arb(input logic [1:0] m, input logic [3:0] msk, input int n);
        logic [1:0] e;
        for (int c = 0; c < 4; c++) wr(8'(4 * c), msk[c] ? 32'h0000_0401 : 32'h0);
        wr(8'h10, {22'h0, m, 8'h01});
        repeat (n) begin
            e = pick(m, msk, rr_top);
            gnt(e);
            unit(1'b0);
            if (m == 2'h3) rr_top = e + 2'h1;
        end
        idle();
    endtask

    initial begin
        {arst_n, reg_wr, reg_rd, unit_done, last_unit, nmi_event, addr_error} = 7'h00;
        {reg_addr, reg_wdata, xfer_end, ext_want, per_set} = 52'h0;
        rr_top = 2'h0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0000_00C0);
        rd(8'h20, 32'h0);
        arb(2'h3, 4'hF, 5);
        arb(2'h3, 4'h9, 3);
        for (int m = 0; m < 3; m++) begin
            arb(2'(m), 4'hE, 2);
            arb(2'(m), 4'hA, 2);
        end
        // NMI with address error, then address error alone, keeps a ready auto channel parked
        wr(8'h00, 32'h0000_0401);
        @(posedge ref_clk);
        {nmi_event, addr_error, xfer_end} <= 6'h31;
        @(posedge ref_clk);
        {nmi_event, addr_error, xfer_end} <= 6'h00;
        rd(8'h00, 32'h0000_0403);
        wr(8'h00, 32'h0000_0401);
        rd(8'h10, 32'h0000_0006);
        wr(8'h10, 32'h0000_0007);
        none();
        rd(8'h10, 32'h0000_0007);
        wr(8'h10, 32'h0000_0005);
        none();
        rd(8'h10, 32'h0000_0005);
        wr(8'h10, 32'h0000_0001);
        gnt(2'h0);
        setup(0, 32'h0000_0421);
        gnt(2'h0);
        chk(grant_ind, 1'b1);
        for (int j = 0; j < 4; j++) begin
            setup(0, {20'h0, 4'(j == 0 ? 1 : j + 4), 8'h01});
            none();
        end
        // Peripheral codes: hidden from the CPU once selected, withdrawn with the grant
        for (int i = 0; i < 6; i++) begin
            idle();
            raise(6'(6'h01 << i));
            repeat (2) @(posedge ref_clk);
            #1 chk(cpu_irq[i], 1'b1);
            wr(8'h00, {20'h0, 4'(4'hA + i), 8'h01});
            repeat (2) @(posedge ref_clk);
            #1 chk(cpu_irq[i], 1'b0);
            wr(8'h10, 32'h1);
            gnt(2'h0);
            chk(grant_burst, 1'b0);
            unit(1'b0);
            repeat (2) @(posedge ref_clk);
            #1 chk(periph_req[i], 1'b0);
            none();
        end
        // Timer in burst keeps its request until the last unit
        setup(0, 32'h0000_0F09);
        raise(6'h20);
        gnt(2'h0);
        chk(grant_burst, 1'b1);
        unit(1'b0);
        #1 chk(grant_valid, 1'b1);
        chk(periph_req[5], 1'b1);
        unit(1'b1);
        #1 chk(grant_valid, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1 chk(periph_req[5], 1'b0);
        setup(0, 32'h0000_0C09);
        raise(6'h04);
        none();
        setup(0, 32'h0000_0F11);
        raise(6'h20);
        none();
        // Level-detected pin on channel 0 with each address mode code
        for (int k = 0; k < 3; k++) begin
            xc = (k == 0) ? 4'h0 : 4'(k + 1);
            setup(0, {20'h0, xc, 8'h01});
            ext_want <= 2'h1;
            gnt(2'h0);
            chk(ext_ack, 2'h1);
            chk(grant_single, k != 0);
            chk(grant_to_dev, k == 1);
            @(posedge ref_clk);
            ext_want <= 2'h0;
            unit(1'b0);
        end
        // Edge mode: a pin left low asks only once
        setup(1, 32'h0000_0005);
        ext_want <= 2'h2;
        gnt(2'h1);
        chk(ext_ack, 2'h2);
        unit(1'b0);
        none();
        @(posedge ref_clk);
        ext_want <= 2'h0;
        setup(2, 32'h0000_0001);
        none();
        complete_run();
    end
endmodule
